//--- common/elt_defines.vh
`ifndef ELT_DEFINES_VH
`define ELT_DEFINES_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define ELT_OFS_CTRL        8'h00
`define ELT_OFS_XFER_SIZE   8'h04
`define ELT_OFS_STATUS      8'h08
`define ELT_OFS_WORD_CNT    8'h0C
`define ELT_OFS_TX_MAC      8'h10
`define ELT_OFS_LOOPBACK    8'h14
`define ELT_OFS_RX_MAC      8'h18
`define ELT_OFS_TRANSFER    8'h1C

// ************************************************************
// field positions and reset values
// ************************************************************
`define ELT_CTRL_LOOP_BIT   0
`define ELT_STAT_START_LSB  0
`define ELT_STAT_STOP_LSB   8
`define ELT_XFER_SIZE_RST   32'h0000_0000

// ************************************************************
// counter slots
// ************************************************************
`define ELT_NUM_CNT         4
`define ELT_IDX_TX_MAC      0
`define ELT_IDX_LOOPBACK    1
`define ELT_IDX_RX_MAC      2
`define ELT_IDX_TRANSFER    3

// ************************************************************
// media preamble patterns, lane 0 in the low byte
// ************************************************************
`define ELT_PRE64_DATA      64'hD555_5555_5555_55FB
`define ELT_PRE64_CTRL      8'h01
`define ELT_PRE32_DATA      32'hD555_55FB
`define ELT_PRE32_CTRL      4'h1

// ************************************************************
// bus responses
// ************************************************************
`define ELT_RESP_OKAY       2'h0
`define ELT_RESP_DECERR     2'h3

`endif

//--- design/elt_lat_counter.v
`timescale 1ns/1ns
// one latency counter with its sticky start and stop flags
module elt_lat_counter #(
  parameter CNT_W = 32
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             clear,
  input  wire             start_evt,
  input  wire             stop_evt,
  output wire             start_flag,
  output wire             stop_flag,
  output wire [CNT_W-1:0] count
);

  reg             start_ff;
  reg             stop_ff;
  reg [CNT_W-1:0] count_ff;
  reg             nxt_start;
  reg             nxt_stop;
  reg [CNT_W-1:0] nxt_count;

  // ************************************************************
  // next state
  // ************************************************************
  always @* begin
    // an event in the clearing cycle still sets its flag
    nxt_start = start_evt | (start_ff & ~clear);  // [R17] [R3]
    nxt_stop  = stop_evt | (stop_ff & ~clear);    // [R17] [R3]
    if (clear) begin
      nxt_count = {CNT_W{1'b0}};                  // [R3]
    end else if (start_ff && !stop_ff) begin
      nxt_count = count_ff + {{(CNT_W-1){1'b0}}, 1'b1}; // [R1] [R16]
    end else begin
      nxt_count = count_ff;                       // [R2]
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      start_ff <= 1'b0;
      stop_ff  <= 1'b0;
      count_ff <= {CNT_W{1'b0}};
    end else begin
      start_ff <= nxt_start;
      stop_ff  <= nxt_stop;
      count_ff <= nxt_count;
    end
  end

  assign start_flag = start_ff;
  assign stop_flag  = stop_ff;
  assign count      = count_ff;

endmodule // elt_lat_counter

//--- design/elt_top.v
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`include "elt_defines.vh"

// Summary of operation
// R1: count only while started and not stopped
// R2: stop flag freezes count for reading
// R3: new loop clears counts and flags
// R4: four counters: tx, loopback, rx, total
// R5: tx start on first accepted stream beat
// R6: tx stop on transmit preamble word
// R7: loopback starts on tx stop event
// R8: receive detector handles aligned and shifted
// R9: loopback stops on first received word
// R10: rx starts on loopback stop event
// R11: rx stop on first beat, valid
// R12: total starts on first fifo write
// R13: word count follows fifo read enable
// R14: total stops when count equals size
// R15: software reads after loop completes
// R16: counters are 32 bits, one per clock
// R17: flags sticky until next loop clear
module elt_top #(
  parameter ADDR_W = 8,
  parameter CNT_W  = 32
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output wire [1:0]        s_axi_bresp,
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              tx_stream_first_beat,
  input  wire              tx_stream_valid,
  input  wire              tx_stream_accept,
  input  wire [63:0]       tx_media_data,
  input  wire [7:0]        tx_media_ctrl,
  input  wire [63:0]       rx_media_data_bus,
  input  wire [7:0]        rx_media_ctrl,
  input  wire              rx_stream_first_beat,
  input  wire              rx_stream_valid,
  input  wire              tx_fifo_write_enable,
  input  wire              rx_fifo_read_enable
);

  // ************************************************************
  // declarations
  // ************************************************************
  reg  [ADDR_W-1:0]          aw_addr_ff;
  reg                        aw_held_ff;
  reg  [31:0]                w_data_ff;
  reg  [3:0]                 w_strb_ff;
  reg                        w_held_ff;
  reg                        bvalid_ff;
  reg  [1:0]                 bresp_ff;
  reg                        rvalid_ff;
  reg  [1:0]                 rresp_ff;
  reg  [31:0]                rdata_ff;
  reg  [31:0]                xfer_size_ff;
  reg  [31:0]                nxt_xfer_size;
  reg                        loop_clear_ff;
  reg  [CNT_W-1:0]           rx_word_count_ff;
  reg                        rx_pre64_ff;
  reg  [31:0]                nxt_rdata;
  reg  [1:0]                 nxt_rresp;
  reg  [1:0]                 nxt_bresp;
  reg                        wr_ctrl;
  reg                        wr_size;
  wire                       aw_take;
  wire                       w_take;
  wire                       ar_take;
  wire                       wr_commit;
  wire [ADDR_W-1:0]          wr_ofs;
  wire [ADDR_W-1:0]          rd_ofs;
  wire                       tx_pre_hit;
  wire                       rx_pre32_hit;
  wire                       rx_first_word;
  wire [`ELT_NUM_CNT-1:0]    start_evt;
  wire [`ELT_NUM_CNT-1:0]    stop_evt;
  wire [`ELT_NUM_CNT-1:0]    start_flag;
  wire [`ELT_NUM_CNT-1:0]    stop_flag;
  wire [`ELT_NUM_CNT*CNT_W-1:0] count_bus;
  wire [31:0]                status_word;

  // ************************************************************
  // write channel
  // ************************************************************
  // address and data are taken independently, in either order
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign wr_commit     = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_ofs        = {aw_addr_ff[ADDR_W-1:2], 2'b00};

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_ff <= {ADDR_W{1'b0}};
      aw_held_ff <= 1'b0;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      w_held_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `ELT_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_ff <= s_axi_awaddr;
        aw_held_ff <= 1'b1;
      end else if (wr_commit) begin
        aw_held_ff <= 1'b0;
      end
      if (w_take) begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        w_held_ff <= 1'b1;
      end else if (wr_commit) begin
        w_held_ff <= 1'b0;
      end
      if (wr_commit) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= nxt_bresp;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always @* begin
    wr_ctrl   = 1'b0;
    wr_size   = 1'b0;
    nxt_bresp = `ELT_RESP_OKAY;
    case (wr_ofs)
      `ELT_OFS_CTRL:      wr_ctrl = 1'b1;
      `ELT_OFS_XFER_SIZE: wr_size = 1'b1;
      // read-only words quietly ignore writes
      `ELT_OFS_STATUS,
      `ELT_OFS_WORD_CNT,
      `ELT_OFS_TX_MAC,
      `ELT_OFS_LOOPBACK,
      `ELT_OFS_RX_MAC,
      `ELT_OFS_TRANSFER:  nxt_bresp = `ELT_RESP_OKAY;
      default:            nxt_bresp = `ELT_RESP_DECERR;
    endcase
  end

  // ************************************************************
  // software registers
  // ************************************************************
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb = gb + 1) begin : g_size_lane
      always @* begin
        if (wr_commit && wr_size && w_strb_ff[gb]) begin
          nxt_xfer_size[gb*8 +: 8] = w_data_ff[gb*8 +: 8];
        end else begin
          nxt_xfer_size[gb*8 +: 8] = xfer_size_ff[gb*8 +: 8];
        end
      end
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      xfer_size_ff  <= `ELT_XFER_SIZE_RST;
      loop_clear_ff <= 1'b0;
    end else begin
      xfer_size_ff  <= nxt_xfer_size;
      // self-clearing: one pulse per write of a one
      loop_clear_ff <= wr_commit && wr_ctrl && w_strb_ff[0] &&
                       w_data_ff[`ELT_CTRL_LOOP_BIT];
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  assign s_axi_arready = !rvalid_ff;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign rd_ofs        = {s_axi_araddr[ADDR_W-1:2], 2'b00};

  assign status_word = {{(24-`ELT_STAT_STOP_LSB){1'b0}},
                        {(8-`ELT_NUM_CNT){1'b0}}, stop_flag,
                        {(8-`ELT_NUM_CNT){1'b0}}, start_flag};

  always @* begin
    nxt_rresp = `ELT_RESP_OKAY;
    case (rd_ofs)
      `ELT_OFS_CTRL:      nxt_rdata = 32'h0000_0000;
      `ELT_OFS_XFER_SIZE: nxt_rdata = xfer_size_ff;
      `ELT_OFS_STATUS:    nxt_rdata = status_word;
      `ELT_OFS_WORD_CNT:  nxt_rdata = rx_word_count_ff;
      `ELT_OFS_TX_MAC:
        nxt_rdata = count_bus[`ELT_IDX_TX_MAC*CNT_W +: CNT_W];
      `ELT_OFS_LOOPBACK:
        nxt_rdata = count_bus[`ELT_IDX_LOOPBACK*CNT_W +: CNT_W];
      `ELT_OFS_RX_MAC:
        nxt_rdata = count_bus[`ELT_IDX_RX_MAC*CNT_W +: CNT_W];
      `ELT_OFS_TRANSFER:
        nxt_rdata = count_bus[`ELT_IDX_TRANSFER*CNT_W +: CNT_W];
      default: begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = `ELT_RESP_DECERR;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= `ELT_RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else begin
      if (ar_take) begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= nxt_rresp;
        rdata_ff  <= nxt_rdata;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ************************************************************
  // traffic detectors
  // ************************************************************
  // transmit side always sends the preamble word lane-aligned
  assign tx_pre_hit = (tx_media_data == `ELT_PRE64_DATA) &&
                      (tx_media_ctrl == `ELT_PRE64_CTRL);  // [R6]

  // shifted case: preamble in low lanes, data in high lanes now
  assign rx_pre32_hit =
    (rx_media_data_bus[31:0] == `ELT_PRE32_DATA) &&
    (rx_media_ctrl[3:0] == `ELT_PRE32_CTRL);               // [R8]

  // aligned case: first data word follows one clock later
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_pre64_ff <= 1'b0;
    end else begin
      rx_pre64_ff <= (rx_media_data_bus == `ELT_PRE64_DATA) &&
                     (rx_media_ctrl == `ELT_PRE64_CTRL);   // [R8]
    end
  end

  assign rx_first_word = rx_pre64_ff | rx_pre32_hit;      // [R9]

  // ************************************************************
  // received word count
  // ************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_word_count_ff <= {CNT_W{1'b0}};
    end else if (loop_clear_ff) begin
      rx_word_count_ff <= {{(CNT_W-1){1'b0}}, rx_fifo_read_enable};
    end else if (rx_fifo_read_enable) begin
      rx_word_count_ff <= rx_word_count_ff +
                          {{(CNT_W-1){1'b0}}, 1'b1};       // [R13]
    end
  end

  // ************************************************************
  // counter events and instances
  // ************************************************************
  assign start_evt[`ELT_IDX_TX_MAC] = tx_stream_first_beat &&
                                      tx_stream_valid &&
                                      tx_stream_accept;   // [R5]
  assign stop_evt[`ELT_IDX_TX_MAC]    = tx_pre_hit;       // [R6]
  assign start_evt[`ELT_IDX_LOOPBACK] = tx_pre_hit;       // [R7]
  assign stop_evt[`ELT_IDX_LOOPBACK]  = rx_first_word;    // [R9]
  assign start_evt[`ELT_IDX_RX_MAC]   = rx_first_word;    // [R10]
  // no ready here: the receive stream cannot be stalled
  assign stop_evt[`ELT_IDX_RX_MAC] = rx_stream_first_beat &&
                                     rx_stream_valid;     // [R11]
  assign start_evt[`ELT_IDX_TRANSFER] = tx_fifo_write_enable; // [R12]
  // size zero never stops, so an idle loop cannot fake a result
  // old loop's count still stands in the clearing cycle: mask it
  assign stop_evt[`ELT_IDX_TRANSFER] =
    (rx_word_count_ff == xfer_size_ff) && !loop_clear_ff &&
    (xfer_size_ff != 32'h0000_0000);                      // [R14] [R3]

  genvar gc;
  generate
    for (gc = 0; gc < `ELT_NUM_CNT; gc = gc + 1) begin : g_cnt // [R4]
      elt_lat_counter #(
        .CNT_W      (CNT_W)
      ) u_cnt (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .clear      (loop_clear_ff),
        .start_evt  (start_evt[gc]),
        .stop_evt   (stop_evt[gc]),
        .start_flag (start_flag[gc]),
        .stop_flag  (stop_flag[gc]),
        .count      (count_bus[gc*CNT_W +: CNT_W])
      );
    end
  endgenerate

  // ************************************************************
  // outputs
  // ************************************************************
  // values are only meaningful once every stop flag reads set
  assign s_axi_bvalid = bvalid_ff;                        // [R15]
  assign s_axi_bresp  = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp  = rresp_ff;
  assign s_axi_rdata  = rdata_ff;

endmodule // elt_top

//--- verification/elt_mac_model.sv
`timescale 1ns/1ns
// ************************************************************
// far-side data paths, one event per cmd cycle
// ************************************************************
module elt_mac_model (
  input  wire logic        aclk,
  input  wire logic [3:0]  cmd,
  output logic             tx_stream_first_beat,
  output logic             tx_stream_valid,
  output logic             tx_stream_accept,
  output logic [63:0]      tx_media_data,
  output logic [7:0]       tx_media_ctrl,
  output logic [63:0]      rx_media_data_bus,
  output logic [7:0]       rx_media_ctrl,
  output logic             rx_stream_first_beat,
  output logic             rx_stream_valid,
  output logic             tx_fifo_write_enable,
  output logic             rx_fifo_read_enable
);
  logic [31:0] noise_ff = 32'h1;
  // payload beside a shifted start changes every cycle
  always @(posedge aclk) noise_ff <= {noise_ff[30:0],
    noise_ff[31] ^ noise_ff[21] ^ noise_ff[1] ^ noise_ff[0]};
  always @* begin
    tx_stream_first_beat = cmd == 4'h1 || cmd == 4'h8;
    tx_stream_valid = tx_stream_first_beat;
    tx_stream_accept = cmd == 4'h1;
    tx_media_data = 64'h0707_0707_0707_0707;
    tx_media_ctrl = 8'hFF;
    rx_media_data_bus = 64'h0707_0707_0707_0707;
    rx_media_ctrl = 8'hFF;
    if (cmd == 4'h2) begin
      tx_media_data = 64'hD555_5555_5555_55FB;
      tx_media_ctrl = 8'h01;
    end
    if (cmd == 4'h3) begin
      rx_media_data_bus = 64'hD555_5555_5555_55FB;
      rx_media_ctrl = 8'h01;
    end
    if (cmd == 4'h4) begin
      rx_media_data_bus = {noise_ff, 32'hD555_55FB};
      rx_media_ctrl = 8'h01;
    end
    rx_stream_first_beat = cmd == 4'h5;
    rx_stream_valid = cmd == 4'h5;
    tx_fifo_write_enable = cmd == 4'h6;
    rx_fifo_read_enable = cmd == 4'h7;
  end
endmodule // elt_mac_model

//--- verification/elt_top_checker.sv
`timescale 1ns/1ns
// ************************************************************
// register bus checks
// ************************************************************
module elt_top_checker #(
  parameter ADDR_W = 8
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_read_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp))
    else $error("read answer dropped early");
  a_read_decode: assert property (
    s_axi_arvalid && s_axi_arready |=>
      s_axi_rresp == ($past(s_axi_araddr) > 8'h1F ? 2'h3 : 2'h0))
    else $error("read response code wrong");
  a_decerr_zero: assert property (
    s_axi_rvalid && s_axi_rresp == 2'h3 |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  a_one_read: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid)
    else $error("write not answered two cycles after take");
  a_write_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_write_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  c_last_reg: cover property (s_axi_arvalid && s_axi_araddr == 8'h1C);
  c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
  c_wr_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
endmodule // elt_top_checker

bind elt_top elt_top_checker #(.ADDR_W(ADDR_W)) i_chk (.*);

//--- verification/ethernet_latency_timers_test.sv
`timescale 1ns/1ns
// ************************************************************
// latency timer bench
// ************************************************************
module ethernet_latency_timers_test;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF, cmd = 4'h0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         tx_stream_first_beat, tx_stream_valid, tx_stream_accept;
  wire  [63:0] tx_media_data, rx_media_data_bus;
  wire  [7:0]  tx_media_ctrl, rx_media_ctrl;
  wire         rx_stream_first_beat, rx_stream_valid;
  wire         tx_fifo_write_enable, rx_fifo_read_enable;
  integer      seed = 68802, n_errors = 0, samples_checked = 0, cyc = 0;
  integer      t, t0, t1, t2, t3, t4, tl, n, k, j;

  elt_top i_dut (.*);
  elt_mac_model i_mac (.*);

  always #25 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  // whole run is well under a thousand cycles
  always @(posedge aclk) if (cyc > 20000) begin
    n_errors++;
    summarize;
  end

  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // handshakes are judged mid-cycle, where ready has settled
  task wr(input [7:0] a, input [31:0] d, input [1:0] e);
    logic pa, pw, rb;
    logic [1:0] r;
    pa = 1; pw = 1; rb = 0;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    while (!rb) begin
      @(negedge aclk);
      rb = s_axi_bvalid; r = s_axi_bresp;
      if (s_axi_awready) pa = 0;
      if (s_axi_wready) pw = 0;
      @(posedge aclk);
      s_axi_awvalid <= pa; s_axi_wvalid <= pw;
    end
    s_axi_bready <= 0;
    // an edge passes so a following call never re-drives in this step
    @(posedge aclk);
    chk({30'h0, r}, {30'h0, e});
  endtask

  task rchk(input [7:0] a, input [31:0] e, input [1:0] er);
    logic pa, rv;
    logic [31:0] d;
    logic [1:0] r;
    pa = 1; rv = 0;
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    while (!rv) begin
      @(negedge aclk);
      rv = s_axi_rvalid; d = s_axi_rdata; r = s_axi_rresp;
      if (s_axi_arready) pa = 0;
      @(posedge aclk);
      s_axi_arvalid <= pa;
    end
    s_axi_rready <= 0;
    @(posedge aclk);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // gap of 1 to 8 idle cycles, then one event cycle
  task ev(input [3:0] c, output integer te);
    integer g;
    g = 1 + {$random(seed)} % 8;
    repeat (g) @(posedge aclk);
    cmd <= c;
    te = cyc;
    @(posedge aclk);
    cmd <= 4'h0;
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (k = 0; k < 8; k++) rchk(k * 4, 0, 0);
    rchk(8'h20, 0, 2'h3);
    wr(8'h24, 1, 2'h3);
    wr(8'h10, 32'hFFFF, 0);
    rchk(8'h10, 0, 0);
    $display("reset and map test done");
    for (k = 0; k < 4; k++) begin
      n = 1 + {$random(seed)} % 5;
      wr(8'h04, n, 0);
      wr(8'h00, 1, 0);
      rchk(8'h08, 0, 0);
      ev(4'h8, t);
      ev(4'h6, t0);
      ev(4'h1, t1);
      ev(4'h2, t2);
      ev(4'h1, t);
      ev(4'h3 + k % 2, t3);
      if (k % 2 == 0) t3 = t3 + 1;
      ev(4'h5, t4);
      for (j = 0; j < n; j++) ev(4'h7, tl);
      ev(4'h6, t);
      ev(4'h3, t);
      rchk(8'h08, 32'h0000_0F0F, 0);
      rchk(8'h0C, n, 0);
      rchk(8'h10, t2 - t1, 0);
      rchk(8'h14, t3 - t2, 0);
      rchk(8'h18, t4 - t3, 0);
      rchk(8'h1C, tl + 1 - t0, 0);
      $display("loop %0d done", k);
    end
    summarize;
  end
endmodule // ethernet_latency_timers_test
